// *** logic/tcc_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_sync (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1, s2, s3, lvl;
  logic next_lvl;

  // A change counts only once the second and third stages agree
  always_comb begin
    next_lvl = lvl;
    if (s2 == s3) begin
      next_lvl = s3;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      lvl <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
    end
  end

  assign level = lvl;
  assign rise = (s2 == s3) && s3 && !lvl;
  assign fall = (s2 == s3) && !s3 && lvl;
endmodule
`default_nettype wire

// *** logic/tcc_prescaler.sv ***
// Counter clock enable: seven bus-clock divisions or the external clock pin
`timescale 1ns/1ns
`default_nettype none
module tcc_prescaler (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [2:0] prescale_select,
  input wire logic ext_rise,
  output logic tick
);
  logic [5:0] div;
  logic [5:0] next_div;
  logic [5:0] mask;

  always_comb begin
    next_div = div + 6'h01;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div <= tcc_pkg::DIV_RESET;
    end else begin
      div <= next_div;
    end
  end

  // Select 000 ticks every cycle, 110 every 64th
  assign mask = 6'((7'h01 << prescale_select) - 7'h01);
  assign tick = (prescale_select == tcc_pkg::PS_EXT) ? ext_rise : ((div & mask) == mask); // (RQ19)
endmodule
`default_nettype wire

// *** logic/tcc_top.sv ***
// Four-channel capture/compare/PWM stage of a 16-bit timer with APB registers
//
// Overview of operation
// (RQ1) Active pin edge copies counter into channel
// (RQ2) Capture edge selectable per channel
// (RQ3) Capture event may request channel interrupt
// (RQ4) Compare match sets, clears or toggles pin
// (RQ5) Compare match may request channel interrupt
// (RQ6) Unbuffered write replaces compare value at once
// (RQ7) Match only when counter reaches value
// (RQ8) Software picks write moment to avoid misses
// (RQ9) Pair 0/1 buffered on pin 0, channel 0 first
// (RQ10) Last written pair register governs after overflow
// (RQ11) Linked channel 1 control unused, pin freed
// (RQ12) Pair 2/3 links likewise on pin 2
// (RQ13) Software writes only inactive channel of pair
// (RQ14) Toggle on overflow inverts pin at modulo
// (RQ15) Level select picks PWM pulse polarity
// (RQ16) Period is modulo plus one counts
// (RQ17) Compare value sets PWM pulse width
// (RQ18) One shared free-running or modulo counter
// (RQ19) Counter clock from prescaler or external pin
// (RQ20) Event sets flag; interrupt when enabled
// (RQ21) No toggle gives 0%, max bit 100%
// (RQ22) Counter wraps to zero after modulo
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module tcc_top #(
  parameter int NUM_CHAN = tcc_pkg::NUM_CHAN,
  parameter int ADDR_W = tcc_pkg::ADDR_W
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic ext_clk_pin,
  input wire logic [NUM_CHAN-1:0] chan_pin_in,
  output logic [NUM_CHAN-1:0] chan_pin_out,
  output logic [NUM_CHAN-1:0] chan_pin_oe,
  output logic [NUM_CHAN-1:0] pin_released,
  output logic [NUM_CHAN-1:0] chan_irq_req
);
  logic [2:0] prescale_select;
  logic [15:0] modulo;
  logic [15:0] counter;
  logic cnt_step;
  logic ovf_flag;
  logic [2:0] next_prescale_select;
  logic [15:0] next_modulo;
  logic [15:0] next_counter;
  logic next_cnt_step;
  logic next_ovf_flag;
  logic tick;
  logic ext_rise;
  logic ovf_evt;
  logic wr_access;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [NUM_CHAN-1:0] pin_level;

  logic [6:0] chan_ctrl [NUM_CHAN];
  logic chan_flag [NUM_CHAN];
  logic [15:0] chan_val [NUM_CHAN];
  logic [NUM_CHAN-1:0] pair_linked;

  assign wr_access = psel && penable && pwrite;

  tcc_pin_sync u_ext_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin(ext_clk_pin),
    .level(),
    .rise(ext_rise),
    .fall()
  );

  tcc_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .prescale_select(prescale_select),
    .ext_rise(ext_rise),
    .tick(tick)
  );

  // Overflow and match events are judged in the cycle after the counter takes a new value
  // Overflow is taken at the wrap to zero, so a compare value of N gives an N-count pulse
  assign ovf_evt = cnt_step && (counter == tcc_pkg::COUNTER_RESET); // (RQ14)

  always_comb begin
    next_prescale_select = prescale_select;
    next_modulo = modulo;
    next_counter = counter;
    next_cnt_step = tick;
    next_ovf_flag = ovf_flag;
    if (wr_access && paddr == tcc_pkg::TIMER_CTRL_OFS && pstrb[0]) begin
      next_prescale_select = pwdata[tcc_pkg::PS_LSB +: 3];
      if (pwdata[tcc_pkg::OVF_FLAG_BIT]) begin
        next_ovf_flag = 1'b0;
      end
    end
    if (wr_access && paddr == tcc_pkg::MODULO_OFS) begin
      if (pstrb[0]) begin
        next_modulo[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        next_modulo[15:8] = pwdata[15:8];
      end
    end
    if (tick) begin
      if (counter == modulo) begin
        next_counter = tcc_pkg::COUNTER_RESET; // (RQ22)
      end else begin
        next_counter = counter + 16'h0001; // (RQ18)
      end
    end
    // Set wins over a clear in the same cycle
    if (ovf_evt) begin
      next_ovf_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale_select <= tcc_pkg::PS_RESET;
      modulo <= tcc_pkg::MODULO_RESET;
      counter <= tcc_pkg::COUNTER_RESET;
      cnt_step <= 1'b0;
      ovf_flag <= 1'b0;
    end else begin
      prescale_select <= next_prescale_select;
      modulo <= next_modulo;
      counter <= next_counter;
      cnt_step <= next_cnt_step;
      ovf_flag <= next_ovf_flag;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      localparam int EVEN = (ch / 2) * 2;
      localparam logic [7:0] SC_ADDR = 8'(tcc_pkg::CHAN_SC_BASE + ch * tcc_pkg::CHAN_STRIDE);
      localparam logic [7:0] VAL_ADDR = 8'(tcc_pkg::CHAN_VAL_BASE + ch * tcc_pkg::CHAN_STRIDE);
      logic rise, fall;
      logic sc_wr, val_wr_lo, val_wr_hi;
      logic suppressed, cap_edge, capture_evt, match_evt, level;
      logic [1:0] els;
      logic [15:0] cmp_val;
      tcc_pkg::tcc_func_e func;
      logic pin_state, next_pin_state;
      logic next_flag;
      logic [6:0] next_ctrl;
      logic [15:0] next_val;

      tcc_pin_sync u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin(chan_pin_in[ch]),
        .level(pin_level[ch]),
        .rise(rise),
        .fall(fall)
      );

      assign sc_wr = wr_access && paddr == SC_ADDR && pstrb[0];
      assign val_wr_lo = wr_access && paddr == VAL_ADDR && pstrb[0];
      assign val_wr_hi = wr_access && paddr == VAL_ADDR && pstrb[1];
      assign pair_linked[ch] = chan_ctrl[EVEN][tcc_pkg::SC_MSB_BIT];
      assign suppressed = (ch != EVEN) && pair_linked[ch]; // (RQ11) (RQ12)
      assign els = chan_ctrl[ch][tcc_pkg::SC_ELSB_BIT:tcc_pkg::SC_ELSA_BIT];

      if (ch == EVEN) begin : g_pair
        logic active_odd, last_odd, next_active_odd, next_last_odd;
        logic pair_wr;
        assign pair_wr = wr_access && pstrb[1:0] != 2'h0 &&
                         (paddr == VAL_ADDR ||
                          paddr == 8'(VAL_ADDR + tcc_pkg::CHAN_STRIDE));
        always_comb begin
          next_active_odd = active_odd;
          next_last_odd = last_odd;
          if (!pair_linked[ch]) begin
            next_active_odd = 1'b0; // (RQ9)
            next_last_odd = 1'b0;
          end else begin
            if (pair_wr) begin
              next_last_odd = (paddr != VAL_ADDR); // (RQ10)
            end
            if (ovf_evt) begin
              next_active_odd = pair_wr ? (paddr != VAL_ADDR) : last_odd; // (RQ10)
            end
          end
        end
        always_ff @(posedge sys_clk or negedge reset_n) begin
          if (!reset_n) begin
            active_odd <= 1'b0;
            last_odd <= 1'b0;
          end else begin
            active_odd <= next_active_odd;
            last_odd <= next_last_odd;
          end
        end
        // Writing the active half simply acts unbuffered
        assign cmp_val = (pair_linked[ch] && active_odd) ? chan_val[ch + 1] : chan_val[ch]; // (RQ13)
      end else begin : g_single
        assign cmp_val = chan_val[ch]; // (RQ6)
      end

      always_comb begin
        if (suppressed || els == tcc_pkg::ELS_OFF) begin
          func = tcc_pkg::FUNC_OFF;
        end else if (chan_ctrl[ch][tcc_pkg::SC_MSB_BIT] && ch == EVEN) begin
          func = tcc_pkg::FUNC_COMPARE; // (RQ9) (RQ12)
        end else if (chan_ctrl[ch][tcc_pkg::SC_MSA_BIT]) begin
          func = tcc_pkg::FUNC_COMPARE;
        end else begin
          func = tcc_pkg::FUNC_CAPTURE;
        end
      end

      assign cap_edge = (els == tcc_pkg::ELS_RISE_TOGGLE && rise) ||
                        (els == tcc_pkg::ELS_FALL_CLEAR && fall) ||
                        (els == tcc_pkg::ELS_ANY_SET && (rise || fall)); // (RQ2)
      assign capture_evt = func == tcc_pkg::FUNC_CAPTURE && cap_edge;
      // Only an exact hit after a counter step matches, so a passed value waits a period
      assign match_evt = func == tcc_pkg::FUNC_COMPARE && cnt_step && counter == cmp_val; // (RQ7)
      // Pulse level is the complement of the compare action
      assign level = !els[0]; // (RQ15)

      always_comb begin
        next_pin_state = pin_state;
        if (func == tcc_pkg::FUNC_COMPARE) begin
          if (chan_ctrl[ch][tcc_pkg::SC_MAX_BIT] && chan_ctrl[ch][tcc_pkg::SC_TOV_BIT]) begin
            next_pin_state = level; // (RQ21)
          end else begin
            if (ovf_evt && chan_ctrl[ch][tcc_pkg::SC_TOV_BIT]) begin
              next_pin_state = !pin_state; // (RQ14) (RQ16)
            end
            if (match_evt) begin
              case (els)
                tcc_pkg::ELS_RISE_TOGGLE: next_pin_state = !pin_state; // (RQ4)
                tcc_pkg::ELS_FALL_CLEAR: next_pin_state = 1'b0; // (RQ4) (RQ17)
                tcc_pkg::ELS_ANY_SET: next_pin_state = 1'b1; // (RQ4) (RQ17)
                default: next_pin_state = pin_state;
              endcase
            end
          end
        end
      end

      always_comb begin
        next_ctrl = chan_ctrl[ch];
        next_flag = chan_flag[ch];
        next_val = chan_val[ch];
        if (sc_wr) begin
          next_ctrl = pwdata[6:0];
          if (pwdata[tcc_pkg::SC_FLAG_BIT]) begin
            next_flag = 1'b0;
          end
        end
        // An event in the clearing cycle still leaves the flag set
        if (capture_evt || match_evt) begin
          next_flag = 1'b1; // (RQ20)
        end
        if (val_wr_lo) begin
          next_val[7:0] = pwdata[7:0]; // (RQ6)
        end
        if (val_wr_hi) begin
          next_val[15:8] = pwdata[15:8]; // (RQ6)
        end
        // Capture beats a software write in the same cycle
        if (capture_evt) begin
          next_val = counter; // (RQ1)
        end
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          chan_ctrl[ch] <= tcc_pkg::CTRL_RESET;
          chan_flag[ch] <= 1'b0;
          chan_val[ch] <= tcc_pkg::VALUE_RESET;
          pin_state <= 1'b0;
        end else begin
          chan_ctrl[ch] <= next_ctrl;
          chan_flag[ch] <= next_flag;
          chan_val[ch] <= next_val;
          pin_state <= next_pin_state;
        end
      end

      assign chan_pin_out[ch] = pin_state;
      assign chan_pin_oe[ch] = func == tcc_pkg::FUNC_COMPARE;
      assign pin_released[ch] = func == tcc_pkg::FUNC_OFF; // (RQ11) (RQ12)
      assign chan_irq_req[ch] = chan_flag[ch] && chan_ctrl[ch][tcc_pkg::SC_IE_BIT]; // (RQ3) (RQ5)
    end
  endgenerate

  // Read data is captured in the setup cycle, so pready can stay high
  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (psel && !penable) begin
      next_prdata = 32'h00000000;
      next_pslverr = 1'b1;
      if (paddr == tcc_pkg::TIMER_CTRL_OFS) begin
        next_prdata[tcc_pkg::PS_LSB +: 3] = prescale_select;
        next_prdata[tcc_pkg::OVF_FLAG_BIT] = ovf_flag;
        next_pslverr = 1'b0;
      end
      if (paddr == tcc_pkg::COUNTER_OFS) begin
        next_prdata[15:0] = counter;
        next_pslverr = 1'b0;
      end
      if (paddr == tcc_pkg::MODULO_OFS) begin
        next_prdata[15:0] = modulo;
        next_pslverr = 1'b0;
      end
      if (paddr == tcc_pkg::PIN_LEVEL_OFS) begin
        next_prdata[NUM_CHAN-1:0] = pin_level;
        next_pslverr = 1'b0;
      end
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (paddr == 8'(tcc_pkg::CHAN_SC_BASE + i * tcc_pkg::CHAN_STRIDE)) begin
          next_prdata[7:0] = {chan_flag[i], chan_ctrl[i]};
          next_pslverr = 1'b0;
        end
        if (paddr == 8'(tcc_pkg::CHAN_VAL_BASE + i * tcc_pkg::CHAN_STRIDE)) begin
          next_prdata[15:0] = chan_val[i];
          next_pslverr = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign pready = 1'b1;
endmodule
`default_nettype wire

// *** pkg/tcc_pkg.sv ***
// Constants shared by the timer capture/compare stage
package tcc_pkg;

  localparam int NUM_CHAN = 4;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;

  // Register byte offsets on the APB port
  localparam logic [7:0] TIMER_CTRL_OFS = 8'h00;
  localparam logic [7:0] COUNTER_OFS = 8'h04;
  localparam logic [7:0] MODULO_OFS = 8'h08;
  localparam logic [7:0] PIN_LEVEL_OFS = 8'h0c;
  localparam logic [7:0] CHAN_SC_BASE = 8'h10;
  localparam logic [7:0] CHAN_VAL_BASE = 8'h20;
  localparam int CHAN_STRIDE = 4;

  // Timer control fields
  localparam int PS_LSB = 0;
  localparam int OVF_FLAG_BIT = 7;
  localparam logic [2:0] PS_EXT = 3'h7;

  // Channel status/control fields
  localparam int SC_MAX_BIT = 0;
  localparam int SC_TOV_BIT = 1;
  localparam int SC_ELSA_BIT = 2;
  localparam int SC_ELSB_BIT = 3;
  localparam int SC_MSA_BIT = 4;
  localparam int SC_MSB_BIT = 5;
  localparam int SC_IE_BIT = 6;
  localparam int SC_FLAG_BIT = 7;

  // Edge/level select encodings
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
  localparam logic [1:0] ELS_ANY_SET = 2'h3;

  // Values after reset
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam logic [15:0] MODULO_RESET = 16'hffff;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [5:0] DIV_RESET = 6'h00;

  typedef enum logic [1:0] {
    FUNC_OFF,
    FUNC_CAPTURE,
    FUNC_COMPARE
  } tcc_func_e;

endpackage

// *** testbench/tb_timer_capture_compare_pwm.sv ***
// Self-checking bench for the timer capture/compare stage
`timescale 1ns/1ns
`default_nettype none
module tb_timer_capture_compare_pwm;
  localparam logic [7:0] CTRL = tcc_pkg::TIMER_CTRL_OFS;
  localparam logic [7:0] CNT = tcc_pkg::COUNTER_OFS;
  localparam logic [7:0] MOD = tcc_pkg::MODULO_OFS;
  localparam logic [7:0] SC = tcc_pkg::CHAN_SC_BASE;
  localparam logic [7:0] VAL = tcc_pkg::CHAN_VAL_BASE;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic ext_clk_pin = 1'b0;
  logic [3:0] src_level = 4'h0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [3:0] chan_pin_in;
  logic [3:0] chan_pin_out;
  logic [3:0] chan_pin_oe;
  logic [3:0] pin_released;
  logic [3:0] chan_irq_req;
  logic [31:0] rd_data;
  logic rd_err;
  logic [15:0] c0;
  logic [15:0] d;
  int err_count = 0;
  int n_tests = 0;
  int hi;
  int per;

  always #4 sys_clk = ~sys_clk;

  tcc_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .chan_pin_in(chan_pin_in),
    .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .pin_released(pin_released),
    .chan_irq_req(chan_irq_req));
  tcc_pin_model u_pins (.src_level(src_level), .chan_pin_oe(chan_pin_oe),
    .chan_pin_out(chan_pin_out), .chan_pin_in(chan_pin_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Counts one full period from a rising edge of the pin to the next
  task automatic measure(input int ch);
    logic prev;
    int k;
    int g;
    prev = 1'b1;
    k = 0;
    g = 0;
    hi = 0;
    per = 0;
    while (k < 2 && g < 1200) begin
      @(posedge sys_clk);
      g++;
      if (k == 1) begin
        per++;
        hi += (chan_pin_out[ch] === 1'b1) ? 1 : 0;
      end
      if (chan_pin_out[ch] === 1'b1 && prev !== 1'b1) k++;
      prev = chan_pin_out[ch];
    end
  endtask

  task automatic high_count(input int ch);
    hi = 0;
    repeat (256) begin
      @(posedge sys_clk);
      hi += (chan_pin_out[ch] === 1'b1) ? 1 : 0;
    end
  endtask

  task automatic t_regs();
    apb(1'b0, MOD, 32'h0); check(rd_data, 32'h0000ffff);
    apb(1'b0, CTRL, 32'h0); check(rd_data, 32'h0);
    apb(1'b0, SC, 32'h0); check(rd_data, 32'h0);
    apb(1'b0, VAL, 32'h0); check(rd_data, 32'h0);
    apb(1'b1, 8'h30, 32'h1234); check(rd_err, 1'b1);
    apb(1'b0, 8'h30, 32'h0); check(rd_data, 32'h0);
  endtask

  task automatic t_counter();
    apb(1'b0, CNT, 32'h0); c0 = rd_data[15:0];
    apb(1'b0, CNT, 32'h0); d = rd_data[15:0] - c0;
    check(d, 16'h3);
    apb(1'b1, CTRL, 32'h7);
    apb(1'b0, CNT, 32'h0); c0 = rd_data[15:0];
    repeat (10) begin
      ext_clk_pin <= 1'b1;
      wait_clk(4);
      ext_clk_pin <= 1'b0;
      wait_clk(4);
    end
    wait_clk(8);
    apb(1'b0, CNT, 32'h0); d = rd_data[15:0] - c0;
    check(d, 16'ha);
    apb(1'b1, CTRL, 32'h0);
  endtask

  task automatic t_pwm();
    apb(1'b1, MOD, 32'h00ff);
    apb(1'b1, VAL, 32'h0080);
    apb(1'b1, SC, 32'h1a);
    wait_clk(600); measure(0);
    check(per, 256);
    check(hi, 128);
    // A smaller value goes in just after the compare, as the interrupt routine would
    @(negedge chan_pin_out[0]);
    apb(1'b1, VAL, 32'h0040);
    wait_clk(600); measure(0);
    check(hi, 64);
    apb(1'b1, SC, 32'h1e);
    wait_clk(600); measure(0);
    check(hi, 192);
    apb(1'b1, SC, 32'h18);
    wait_clk(600); high_count(0);
    check(hi, 0);
    apb(1'b1, SC, 32'h1b);
    wait_clk(600); high_count(0);
    check(hi, 256);
  endtask

  task automatic t_pair();
    // Odd halves drive first, so only the link can free their pins
    apb(1'b1, SC + 8'h04, 32'h18);
    apb(1'b1, SC + 8'h0c, 32'h18);
    apb(1'b1, SC, 32'h2a);
    wait_clk(600); measure(0);
    check(hi, 64);
    check({pin_released[1], chan_pin_oe[1]}, 2'b10);
    // Software writes only the idle half of the pair
    apb(1'b1, VAL + 8'h04, 32'h20);
    wait_clk(600); measure(0);
    check(hi, 32);
    apb(1'b1, VAL, 32'h60);
    wait_clk(600); measure(0);
    check(hi, 96);
    apb(1'b1, VAL + 8'h08, 32'h30);
    apb(1'b1, SC + 8'h08, 32'h2a);
    wait_clk(600); measure(2);
    check(hi, 48);
    check({pin_released[3], chan_pin_oe[3]}, 2'b10);
    apb(1'b1, SC, 32'h0);
    apb(1'b1, SC + 8'h08, 32'h0);
  endtask

  task automatic t_capture();
    apb(1'b1, MOD, 32'hffff);
    // Clears any flag left from the compare use of this channel
    apb(1'b1, SC + 8'h04, 32'hc8);
    src_level[1] <= 1'b1;
    wait_clk(10); check(chan_irq_req[1], 1'b0);
    apb(1'b0, CNT, 32'h0); c0 = rd_data[15:0];
    src_level[1] <= 1'b0;
    wait_clk(10); check(chan_irq_req[1], 1'b1);
    apb(1'b0, VAL + 8'h04, 32'h0); d = rd_data[15:0] - c0;
    // Capture lands five counts after the value read, and a window around that is accepted
    check(d >= 16'h2 && d <= 16'ha, 1'b1);
    apb(1'b1, SC + 8'h04, 32'hc8);
    wait_clk(1); check(chan_irq_req[1], 1'b0);
    for (int c = 1; c < 4; c++) begin
      apb(1'b1, SC + 8'h0c, 32'hc0 | 32'(c << 2));
      src_level[3] <= 1'b1;
      wait_clk(10); check(chan_irq_req[3], c != 2);
      apb(1'b1, SC + 8'h0c, 32'hc0 | 32'(c << 2));
      src_level[3] <= 1'b0;
      wait_clk(10); check(chan_irq_req[3], c != 1);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    wait_clk(4);
    reset_n <= 1'b1;
    t_regs();
    t_counter();
    t_pwm();
    t_pair();
    t_capture();
    stop_test();
  end

  // The whole sequence needs about 9000 cycles
  initial begin
    wait_clk(40000);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire

// *** testbench/tcc_pin_model.sv ***
// Outside world at the channel pins: event sources and loads
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model #(
  parameter int NUM_CHAN = 4
) (
  input wire logic [NUM_CHAN-1:0] src_level,
  input wire logic [NUM_CHAN-1:0] chan_pin_oe,
  input wire logic [NUM_CHAN-1:0] chan_pin_out,
  output logic [NUM_CHAN-1:0] chan_pin_in
);
  // A driven pin reads back its drive; the source yields then, so no contention
  assign chan_pin_in = (chan_pin_oe & chan_pin_out) | (~chan_pin_oe & src_level);
endmodule
`default_nettype wire

// *** testbench/tcc_top_chk.sv ***
// Port checker for the timer capture/compare stage, bound to its top
`timescale 1ns/1ns
`default_nettype none
module tcc_top_chk #(
  parameter int NUM_CHAN = 4,
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic ext_clk_pin,
  input wire logic [NUM_CHAN-1:0] chan_pin_in,
  input wire logic [NUM_CHAN-1:0] chan_pin_out,
  input wire logic [NUM_CHAN-1:0] chan_pin_oe,
  input wire logic [NUM_CHAN-1:0] pin_released,
  input wire logic [NUM_CHAN-1:0] chan_irq_req
);
  // Shadow of each channel control word, rebuilt from the bus writes seen
  logic [7:0] sc [NUM_CHAN];
  logic [7:0] next_sc [NUM_CHAN];
  logic [NUM_CHAN-1:0] exp_oe;
  logic [NUM_CHAN-1:0] exp_rel;
  logic [NUM_CHAN-1:0] ie;
  logic mapped;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  assign mapped = (paddr[1:0] == 2'h0) && (paddr < ADDR_W'(8'h30));

  always_comb begin
    next_sc = sc;
    for (int n = 0; n < NUM_CHAN; n++) begin
      if (psel && penable && pwrite && pstrb[0] && paddr == ADDR_W'(
          int'(tcc_pkg::CHAN_SC_BASE) + tcc_pkg::CHAN_STRIDE * n)) begin
        next_sc[n] = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int n = 0; n < NUM_CHAN; n++) sc[n] <= 8'h00;
    end else begin
      sc <= next_sc;
    end
  end

  // Odd half of a linked pair gives up its pin whatever its own control says
  always_comb begin
    logic link;
    logic comp;
    link = 1'b0;
    comp = 1'b0;
    for (int n = 0; n < NUM_CHAN; n++) begin
      link = (n % 2 == 1) && sc[n & ~1][tcc_pkg::SC_MSB_BIT];
      comp = (sc[n][3:2] != 2'h0) && (sc[n][tcc_pkg::SC_MSA_BIT]
             || (n % 2 == 0 && sc[n][tcc_pkg::SC_MSB_BIT]));
      exp_oe[n] = comp && !link;
      exp_rel[n] = (sc[n][3:2] == 2'h0) || link;
      ie[n] = sc[n][tcc_pkg::SC_IE_BIT];
    end
  end

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence bad_access_s;
    psel && penable && !mapped;
  endsequence

  a_ready_always: assert property (pready)
    else $error("pready not high");
  a_unmapped_err: assert property (setup_s ##1 bad_access_s |-> pslverr)
    else $error("no error on unmapped address");
  a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on mapped address");
  a_unmapped_zero: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_drive_enable: assert property (chan_pin_oe == exp_oe)
    else $error("pin drive enable wrong for channel setup");
  a_pin_release: assert property (pin_released == exp_rel)
    else $error("pin release wrong for channel setup");
  a_irq_gated: assert property ((chan_irq_req & ~ie) == '0)
    else $error("interrupt request without enable");
  // Four settled cycles cover the two-stage pipeline behind the pin
  a_zero_duty: assert property (
    (sc[0][3:0] == 4'h8 && sc[0][tcc_pkg::SC_MSA_BIT]) [*4] |-> !$rose(chan_pin_out[0]))
    else $error("pin rose with toggle off and clear on compare");
endmodule

bind tcc_top tcc_top_chk #(.NUM_CHAN(NUM_CHAN), .ADDR_W(ADDR_W)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .chan_pin_in(chan_pin_in),
  .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .pin_released(pin_released),
  .chan_irq_req(chan_irq_req));
`default_nettype wire
